// ---- hw/dpd_pkg.sv ----
package dpd_pkg;

    // ==========================================================
    // Control word two field positions
    localparam int CW2_CDS_LSB = 0;
    localparam int CW2_MDS_LSB = 2;
    localparam int CW2_RAMP_BYPASS = 5;
    localparam int CW2_LOAD_COMP = 7;
    localparam int CW2_DROOP = 8;
    localparam int CW2_SPEED_CTRL = 9;
    localparam int CW2_TORQUE_MODE = 11;
    localparam int CW2_SIGN_OF_LIFE = 15;

    // ==========================================================
    // Block selection and positioning word positions
    localparam int BSW_BLOCK_LSB = 0;
    localparam int PCW_SET_REF = 1;
    localparam int PCW_REF_CAM = 2;

    // ==========================================================
    // Normalization references
    localparam logic [15:0] SPEED_SHORT_REF = 16'h4000;
    localparam logic [31:0] SPEED_LONG_REF = 32'h40000000;
    localparam int SPEED_SHORT_SHIFT = 14;
    localparam int SPEED_LONG_SHIFT = 30;
    localparam logic [31:0] GAIN_MAX = 32'h003D0900;
    localparam logic [15:0] TORQUE_RED_FULL = 16'h4000;
    localparam int TORQUE_RED_SHIFT = 14;

    // ==========================================================
    // Reset values
    localparam logic [15:0] CW_RESET = 16'h0000;
    localparam logic [31:0] SP_RESET = 32'h00000000;

    typedef enum logic [2:0] {
        DPD_IDLE = 3'b001,
        DPD_SCALE = 3'b010,
        DPD_DONE = 3'b100
    } dpd_state_e;

    typedef struct packed {
        logic [1:0] command_data_set;
        logic [2:0] motor_data_set;
        logic ramp_bypass;
        logic load_comp;
        logic droop;
        logic speed_ctrl_brake;
        logic torque_mode;
        logic sign_of_life;
    } dpd_cw2_s;

    typedef struct packed {
        logic [5:0] traversing_block_select;
        logic set_reference;
        logic reference_cam;
    } dpd_pos_s;

    typedef struct packed {
        logic [15:0] control_word_two;
        logic [15:0] speed_setpoint_short;
        logic [31:0] speed_setpoint_long;
        logic [31:0] position_deviation_setpoint;
        logic [31:0] position_gain_setpoint;
        logic [15:0] torque_reduction_setpoint;
        logic [15:0] block_selection_word;
        logic [15:0] positioning_control_word;
    } dpd_telegram_s;

endpackage

// ---- hw/dpd_scaler.sv ----
`timescale 1ns/1ps
module dpd_scaler
    import dpd_pkg::*;
(
    input wire logic signed [31:0] value_i,
    input wire logic [31:0] ref_i,
    input wire logic [5:0] shift_i,
    output logic signed [31:0] scaled_o
);

    // ==========================================================
    // Proportional scaling: value * ref / 2^shift
    logic signed [63:0] product;

    always_comb begin
        product = value_i * $signed({1'b0, ref_i});
        scaled_o = 32'(product >>> shift_i);
    end

endmodule

// ---- hw/dpd_torque_red.sv ----
`timescale 1ns/1ps
module dpd_torque_red
    import dpd_pkg::*;
(
    input wire logic [15:0] percent_i,
    input wire logic [15:0] limit_i,
    input wire logic [15:0] torque_ref_i,
    output logic [15:0] reduction_o
);

    // ==========================================================
    // Percent of active limit, normalized to torque reference
    logic [31:0] absolute;
    logic [31:0] clipped;
    logic [47:0] norm;

    always_comb begin
        clipped = (percent_i > TORQUE_RED_FULL) ? 32'(TORQUE_RED_FULL) : 32'(percent_i);
        absolute = (clipped * 32'(limit_i)) >> TORQUE_RED_SHIFT;
        if (torque_ref_i == 16'h0000) begin
            norm = 48'h0;
        end else begin
            norm = ({16'h0, absolute} << TORQUE_RED_SHIFT) / 48'(torque_ref_i);
        end
        reduction_o = (norm > 48'(TORQUE_RED_FULL)) ? TORQUE_RED_FULL : norm[15:0];
    end

endmodule

// ---- hw/dpd_decoder.sv ----
// Behaviour
// - CW2 bits 0-1 select command data set
// - CW2 bits 2-4 select motor data set
// - Bit 5 bypasses ramp if extended generator
// - Bit 7 enables load compensation
// - Bit 8 enables droop, not servo
// - Bit 9 enables speed controller and brake
// - Bit 11 selects torque control mode
// - Bit 15 is sign-of-life toggle active
// - Short speed setpoint is signed 16-bit
// - Short 4000 hex equals reference speed
// - Long speed setpoint is signed 32-bit
// - Long 40000000 hex equals reference speed
// - Position deviation uses encoder position format
// - Gain in 0.001 1/s, 0 to 4000
// - Zero gain deactivates dynamic servo control
// - Torque reduction percent normalized to reference
// - Block word bits 0-5 select block
// - Positioning bit 1 sets reference point
// - Positioning bit 2 reference cam active
`timescale 1ns/1ps
module dpd_decoder
    import dpd_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic telegram_valid_i,
    input wire dpd_telegram_s telegram_i,
    input wire logic ext_setpoint_gen_i,
    input wire logic servo_mode_i,
    input wire logic [31:0] reference_speed_i,
    input wire logic [15:0] torque_limit_i,
    input wire logic [15:0] torque_reference_i,
    output logic busy_o,
    output logic update_o,
    output dpd_cw2_s cw2_o,
    output logic ramp_bypass_o,
    output logic droop_o,
    output logic signed [31:0] speed_short_o,
    output logic signed [31:0] speed_long_o,
    output logic signed [31:0] speed_short_scaled_o,
    output logic signed [31:0] speed_long_scaled_o,
    output logic [31:0] position_deviation_o,
    output logic [31:0] position_gain_o,
    output logic gain_range_err_o,
    output logic servo_ctrl_active_o,
    output logic [15:0] torque_reduction_o,
    output dpd_pos_s pos_o
);

    // ==========================================================
    // Telegram capture
    dpd_state_e state_q;
    dpd_state_e state_d;
    dpd_telegram_s tel_q;
    logic signed [31:0] short_scaled;
    logic signed [31:0] long_scaled;
    logic [15:0] torque_red;

    function automatic dpd_cw2_s decode_cw2(input logic [15:0] w);
        dpd_cw2_s c;
        c.command_data_set = w[CW2_CDS_LSB +: 2];
        c.motor_data_set = w[CW2_MDS_LSB +: 3];
        c.ramp_bypass = w[CW2_RAMP_BYPASS];
        c.load_comp = w[CW2_LOAD_COMP];
        c.droop = w[CW2_DROOP];
        c.speed_ctrl_brake = w[CW2_SPEED_CTRL];
        c.torque_mode = w[CW2_TORQUE_MODE];
        c.sign_of_life = w[CW2_SIGN_OF_LIFE];
        return c;
    endfunction

    function automatic dpd_pos_s decode_pos(input logic [15:0] blk, input logic [15:0] pcw);
        dpd_pos_s p;
        p.traversing_block_select = blk[BSW_BLOCK_LSB +: 6];
        p.set_reference = pcw[PCW_SET_REF];
        p.reference_cam = pcw[PCW_REF_CAM];
        return p;
    endfunction

    // ==========================================================
    // Sequencer: capture, scale, publish
    always_comb begin
        case (state_q)
            DPD_IDLE: state_d = telegram_valid_i ? DPD_SCALE : DPD_IDLE;
            DPD_SCALE: state_d = DPD_DONE;
            DPD_DONE: state_d = DPD_IDLE;
            default: state_d = DPD_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state_q <= DPD_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            tel_q <= '0;
        end else if (state_q == DPD_IDLE && telegram_valid_i) begin
            tel_q <= telegram_i;
        end
    end

    assign busy_o = (state_q != DPD_IDLE);

    // ==========================================================
    // Arithmetic
    dpd_scaler u_short_scaler (
        .value_i(32'(signed'(tel_q.speed_setpoint_short))),
        .ref_i(reference_speed_i),
        .shift_i(6'(SPEED_SHORT_SHIFT)),
        .scaled_o(short_scaled)
    );

    dpd_scaler u_long_scaler (
        .value_i(signed'(tel_q.speed_setpoint_long)),
        .ref_i(reference_speed_i),
        .shift_i(6'(SPEED_LONG_SHIFT)),
        .scaled_o(long_scaled)
    );

    dpd_torque_red u_torque_red (
        .percent_i(tel_q.torque_reduction_setpoint),
        .limit_i(torque_limit_i),
        .torque_ref_i(torque_reference_i),
        .reduction_o(torque_red)
    );

    // ==========================================================
    // Published outputs
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            update_o <= 1'b0;
        end else begin
            update_o <= (state_q == DPD_SCALE);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            cw2_o <= '0;
            ramp_bypass_o <= 1'b0;
            droop_o <= 1'b0;
            pos_o <= '0;
        end else if (state_q == DPD_SCALE) begin
            // Reserved bits never reach any output
            cw2_o <= decode_cw2(tel_q.control_word_two);
            ramp_bypass_o <= tel_q.control_word_two[CW2_RAMP_BYPASS] & ext_setpoint_gen_i;
            droop_o <= tel_q.control_word_two[CW2_DROOP] & ~servo_mode_i;
            pos_o <= decode_pos(tel_q.block_selection_word,
                tel_q.positioning_control_word);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            speed_short_o <= SP_RESET;
            speed_long_o <= SP_RESET;
            speed_short_scaled_o <= SP_RESET;
            speed_long_scaled_o <= SP_RESET;
        end else if (state_q == DPD_SCALE) begin
            speed_short_o <= 32'(signed'(tel_q.speed_setpoint_short));
            speed_long_o <= signed'(tel_q.speed_setpoint_long);
            speed_short_scaled_o <= short_scaled;
            speed_long_scaled_o <= long_scaled;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            position_deviation_o <= SP_RESET;
            position_gain_o <= SP_RESET;
            gain_range_err_o <= 1'b0;
            servo_ctrl_active_o <= 1'b0;
        end else if (state_q == DPD_SCALE) begin
            // Passed unchanged in encoder position format
            position_deviation_o <= tel_q.position_deviation_setpoint;
            position_gain_o <= tel_q.position_gain_setpoint;
            gain_range_err_o <= (tel_q.position_gain_setpoint > GAIN_MAX);
            servo_ctrl_active_o <= (tel_q.position_gain_setpoint != SP_RESET) &&
                (tel_q.position_gain_setpoint <= GAIN_MAX);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            torque_reduction_o <= CW_RESET;
        end else if (state_q == DPD_SCALE) begin
            torque_reduction_o <= torque_red;
        end
    end

endmodule

// ---- tb/dpd_decoder_properties.sv ----
`timescale 1ns/1ps
module dpd_decoder_properties
    import dpd_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic telegram_valid_i,
    input wire dpd_telegram_s telegram_i,
    input wire logic ext_setpoint_gen_i,
    input wire logic servo_mode_i,
    input wire logic busy_o,
    input wire logic update_o,
    input wire dpd_cw2_s cw2_o,
    input wire logic ramp_bypass_o,
    input wire logic droop_o,
    input wire logic signed [31:0] speed_short_o,
    input wire logic signed [31:0] speed_long_o,
    input wire logic servo_ctrl_active_o,
    input wire dpd_pos_s pos_o
);
    logic [15:0] cw, ss, bw, pw;
    logic [31:0] gn;
    assign cw = telegram_i.control_word_two;
    assign ss = telegram_i.speed_setpoint_short;
    assign bw = telegram_i.block_selection_word;
    assign pw = telegram_i.positioning_control_word;
    assign gn = telegram_i.position_gain_setpoint;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    // ==========================================================
    // Take, then answer two edges later
    sequence s_take; telegram_valid_i && !busy_o; endsequence
    sequence s_answer; busy_o && !update_o ##1 busy_o && update_o ##1 !busy_o && !update_o;
    endsequence
    property p_walk; s_take |=> s_answer; endproperty
    property p_cds; update_o |-> cw2_o.command_data_set == $past(cw[1:0], 2); endproperty
    property p_mds; update_o |-> cw2_o.motor_data_set == $past(cw[4:2], 2); endproperty
    property p_ramp; update_o |->
        ramp_bypass_o == ($past(cw[5], 2) && $past(ext_setpoint_gen_i)); endproperty
    property p_droop; update_o |->
        droop_o == ($past(cw[8], 2) && !$past(servo_mode_i)); endproperty
    property p_bits; update_o |-> {cw2_o.load_comp, cw2_o.speed_ctrl_brake, cw2_o.torque_mode,
        cw2_o.sign_of_life} == {$past(cw[7], 2), $past(cw[9], 2), $past(cw[11], 2),
        $past(cw[15], 2)}; endproperty
    property p_short; update_o |-> speed_short_o == {{16{$past(ss[15], 2)}}, $past(ss, 2)};
    endproperty
    property p_long; update_o |-> speed_long_o == $past(telegram_i.speed_setpoint_long, 2);
    endproperty
    property p_gain; update_o |-> servo_ctrl_active_o ==
        ($past(gn, 2) != 0 && $past(gn, 2) <= GAIN_MAX); endproperty
    property p_pos; update_o |-> pos_o == {$past(bw[5:0], 2), $past(pw[1], 2), $past(pw[2], 2)};
    endproperty
    property p_hold; !update_o |-> $stable(pos_o) && $stable(speed_short_o); endproperty
    a_walk: assert property (p_walk) else $error("answer timing wrong");
    a_cds: assert property (p_cds) else $error("command set wrong");
    a_mds: assert property (p_mds) else $error("motor set wrong");
    a_ramp: assert property (p_ramp) else $error("ramp bypass wrong");
    a_droop: assert property (p_droop) else $error("droop wrong");
    a_bits: assert property (p_bits) else $error("control bits wrong");
    a_short: assert property (p_short) else $error("short speed wrong");
    a_long: assert property (p_long) else $error("long speed wrong");
    a_gain: assert property (p_gain) else $error("servo control wrong");
    a_pos: assert property (p_pos) else $error("positioning wrong");
    a_hold: assert property (p_hold) else $error("output moved without update");
endmodule
bind dpd_decoder dpd_decoder_properties u_props (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .telegram_valid_i(telegram_valid_i),
    .telegram_i(telegram_i),
    .ext_setpoint_gen_i(ext_setpoint_gen_i),
    .servo_mode_i(servo_mode_i),
    .busy_o(busy_o),
    .update_o(update_o),
    .cw2_o(cw2_o),
    .ramp_bypass_o(ramp_bypass_o),
    .droop_o(droop_o),
    .speed_short_o(speed_short_o),
    .speed_long_o(speed_long_o),
    .servo_ctrl_active_o(servo_ctrl_active_o),
    .pos_o(pos_o)
);

// ---- tb/dpd_master_model.sv ----
`timescale 1ns/1ps
module dpd_master_model
    import dpd_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic go_i,
    input wire logic resv_i,
    input wire dpd_telegram_s tel_i,
    output logic valid_o,
    output dpd_telegram_s tel_o
);
    // Reserved bits driven to zero unless resv_i is high
    function automatic dpd_telegram_s scrub(input dpd_telegram_s w);
        dpd_telegram_s c;
        c = w;
        c.control_word_two = w.control_word_two & 16'h8BBF;
        c.block_selection_word = w.block_selection_word & 16'h803F;
        c.positioning_control_word = w.positioning_control_word & 16'h0027;
        return c;
    endfunction
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            valid_o <= 1'b0;
            tel_o <= '0;
        end else begin
            valid_o <= go_i;
            if (go_i) begin
                tel_o <= resv_i ? tel_i : scrub(tel_i);
            end else begin
                // Stale words never look valid
                tel_o <= ~tel_o;
            end
        end
    end
endmodule

// ---- tb/test_drive_process_data_decoder.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; $display("BAD %0t mismatch", $time); end end
module test_drive_process_data_decoder
    import dpd_pkg::*;
;
    typedef struct packed {logic [15:0] cw, sp; logic [31:0] gn; logic [15:0] bw, pw;
        logic [10:0] ec; logic [31:0] es; logic ea; logic [7:0] ep;} dpd_row_s;
    logic clk_sys_i = 0, sys_rst_i = 1, go = 0, resv = 0;
    logic ext_setpoint_gen_i = 1, servo_mode_i = 0, telegram_valid_i, busy_o, update_o;
    logic [31:0] reference_speed_i = 32'h000003E8, position_deviation_o, position_gain_o;
    logic [15:0] torque_limit_i = 16'h4000, torque_reference_i = 16'h4000, torque_reduction_o;
    logic ramp_bypass_o, droop_o, gain_range_err_o, servo_ctrl_active_o;
    logic signed [31:0] speed_short_o, speed_long_o, speed_short_scaled_o, speed_long_scaled_o;
    dpd_telegram_s tel = '0, telegram_i, t;
    dpd_cw2_s cw2_o;
    dpd_pos_s pos_o;
    int errors = 0, cmp_count = 0, ups;
    dpd_row_s rows [4] = '{
        '{16'h0001, 16'h4000, 32'h0, 16'h003F, 16'h0002, 11'h200, 32'h3E8, 1'b0, 8'hFE},
        '{16'h8BBE, 16'hC000, 32'hA2C2A, 16'h15, 16'h4, 11'h5FF, 32'hFFFFFC18, 1'b1, 8'h55},
        '{16'h0014, 16'h7FFF, GAIN_MAX, 16'h0000, 16'h0006, 11'h140, 32'h7CF, 1'b1, 8'h03},
        '{16'h0000, 16'h0000, 32'h3D0901, 16'h0000, 16'h0000, 11'h000, 32'h0, 1'b0, 8'h00}};
    dpd_decoder dut (.*);
    dpd_master_model u_master (.clk_sys_i, .sys_rst_i, .go_i(go), .resv_i(resv), .tel_i(tel),
        .valid_o(telegram_valid_i), .tel_o(telegram_i));
    initial begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    task automatic final_report();
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Holds go for n edges, counts update pulses
    task automatic send(input dpd_telegram_s w, input int n);
        @(posedge clk_sys_i);
        tel <= w;
        go <= 1'b1;
        repeat (n) @(posedge clk_sys_i);
        go <= 1'b0;
        ups = 0;
        repeat (8) begin
            @(posedge clk_sys_i);
            #1 ups += int'(update_o === 1'b1);
        end
        `CHK(ups, 1)
    endtask
    initial begin
        #50000 errors++;
        final_report();
    end
    // ==========================================================
    // Main sequence
    initial begin
        repeat (16) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        #1 `CHK({update_o, busy_o, cw2_o, pos_o, speed_long_o}, '0)
        foreach (rows[i]) begin
            t = '0;
            t.control_word_two = rows[i].cw;
            t.speed_setpoint_short = rows[i].sp;
            t.speed_setpoint_long = SPEED_LONG_REF;
            t.position_deviation_setpoint = 32'hFFFF8001;
            t.position_gain_setpoint = rows[i].gn;
            t.torque_reduction_setpoint = 16'h2000;
            t.block_selection_word = rows[i].bw;
            t.positioning_control_word = rows[i].pw;
            send(t, 1);
            `CHK(cw2_o, rows[i].ec)
            `CHK(speed_short_o, {{16{rows[i].sp[15]}}, rows[i].sp})
            `CHK(speed_short_scaled_o, rows[i].es)
            `CHK(speed_long_scaled_o, 32'h000003E8)
            `CHK(speed_long_o, SPEED_LONG_REF)
            `CHK(position_gain_o, rows[i].gn)
            `CHK(position_deviation_o, 32'hFFFF8001)
            `CHK(gain_range_err_o, rows[i].gn > GAIN_MAX)
            `CHK(servo_ctrl_active_o, rows[i].ea)
            `CHK(torque_reduction_o, 16'h2000)
            `CHK(pos_o, rows[i].ep)
        end
        t.control_word_two = 16'hFFFF;
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_sys_i);
            ext_setpoint_gen_i <= i[0];
            servo_mode_i <= !i[0];
            send(t, 1);
            `CHK(ramp_bypass_o, i[0])
            `CHK(droop_o, i[0])
        end
        @(posedge clk_sys_i);
        resv <= 1'b1;
        torque_limit_i <= 16'h2000;
        t.speed_setpoint_long = 32'hC0000000;
        t.control_word_two = 16'h7440;
        t.block_selection_word = 16'h7FC0;
        t.positioning_control_word = 16'hFFF9;
        send(t, 1);
        `CHK(cw2_o, 11'h000)
        `CHK(pos_o, 8'h00)
        `CHK(speed_long_scaled_o, 32'hFFFFFC18)
        `CHK(torque_reduction_o, 16'h1000)
        // Mid-run reset clears every published output
        @(posedge clk_sys_i);
        sys_rst_i <= 1'b1;
        resv <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        #1 `CHK({update_o, busy_o, cw2_o, pos_o, speed_long_scaled_o, torque_reduction_o}, '0)
        t.control_word_two = 16'h0001;
        send(t, 2);
        `CHK(cw2_o, 11'h200)
        final_report();
    end
endmodule
